/* hw/ulms_pkg.sv */
// Constants, register map and carrier types of the line and modem status block.
// Assumes a 32-bit APB slave port and one clock domain.
`default_nettype none

package ulms_pkg;

  // Register byte offsets on the APB port.
  localparam logic [7:0] OFS_LINE_STATUS = 8'h00;
  localparam logic [7:0] OFS_MODEM_STATUS = 8'h04;
  localparam logic [7:0] OFS_SCRATCH = 8'h08;
  localparam logic [7:0] OFS_CONTROL = 8'h0c;

  // Line status bit positions.
  localparam int LS_READY = 0;
  localparam int LS_OVERRUN = 1;
  localparam int LS_PARITY = 2;
  localparam int LS_FRAMING = 3;
  localparam int LS_BREAK = 4;
  localparam int LS_THR_EMPTY = 5;
  localparam int LS_TX_IDLE = 6;
  localparam int LS_FIFO_ERR = 7;

  // Control register fields: modem_control in bits 3:0, feature_control in bits 15:8.
  localparam int CTL_MC_DTR = 0;
  localparam int CTL_MC_RTS = 1;
  localparam int CTL_MC_OUT1 = 2;
  localparam int CTL_MC_OUT2 = 3;
  localparam int CTL_LOOP = 4;
  localparam int CTL_FIFO = 5;
  localparam int CTL_AUTO_CTS = 6;
  localparam int CTL_MSI_EN = 7;
  localparam int CTL_FEATURE_CONTROL_LSB = 8;
  localparam int CTL_WIDTH = 16;
  localparam logic [15:0] CTL_RESET = 16'h0000;

  // Feature control and enhanced mode fields.
  localparam int FEATURE_CONTROL_SWAP = 6;
  localparam int EM_CNT_SEL = 0;
  localparam int EM_CNT_ALT = 1;
  localparam int EM_DIR_INV = 3;
  localparam int EM_HYST_LSB = 4;
  localparam int EM_IMMEDIATE = 6;
  localparam int EM_SAMPLE_16X = 7;
  localparam logic [7:0] ENHANCED_MODE_SELECT_RESET = 8'h80;
  localparam logic [7:0] SCRATCH_RESET = 8'hff;

  // Flow-control hysteresis in characters, indexed by {enhanced 5:4, feature 1:0}.
  localparam logic [5:0] HYST_TABLE [16] = '{
    6'h00, 6'h04, 6'h06, 6'h08, 6'h08, 6'h10, 6'h18, 6'h20,
    6'h28, 6'h2c, 6'h30, 6'h34, 6'h0c, 6'h14, 6'h1c, 6'h24};

  // Error tags that travel with each received character.
  typedef struct packed {
    logic brk;
    logic frm;
    logic par;
  } ulms_tag_t;

  // A completed character as reported by the receiver: one-cycle valid plus tags.
  typedef struct packed {
    logic valid;
    ulms_tag_t tag;
  } ulms_rx_char_t;

endpackage

`default_nettype wire

/* hw/ulms_status.sv */
// Line status, modem status, scratch and enhanced mode logic of one serial channel.
// Assumes the receiver, transmitter and data FIFOs sit outside and report events here.
//
// Functional notes
// RULE1: Ready bit is set while any received character waits, clear when none.
// RULE2: Character arriving with receive FIFO full sets overrun and is not stored.
// RULE3: Parity flag shows the tag of the character at the read head.
// RULE4: Framing flag shows the missing stop bit tag of the head character.
// RULE5: Break is flagged; a long break stores only one break character.
// RULE6: Holding-empty flag follows the transmit holding register or FIFO being empty.
// RULE7: Transmitter-empty needs both holding store and shifter empty.
// RULE8: FIFO error summary is high while any stored byte has an error tag.
// RULE9: Modem line level changes set change flags; interrupt when enabled.
// RULE10: Ring change flag sets only when the ring pin rises.
// RULE11: Automatic clear-to-send stops transmission after current character while input high.
// RULE12: Modem levels are inverted pins, or modem control bits in loopback.
// RULE13: Eight-bit scratch byte resets to all ones.
// RULE14: With swap set, scratch writes go to the enhanced mode register.
// RULE15: Enhanced bits 1:0 select receive, transmit or alternating level report.
// RULE16: Alternating mode reports receive first after programming, then alternates.
// RULE17: Enhanced bit 3 inverts the half-duplex direction output.
// RULE18: Enhanced bits 5:4 and feature bits 1:0 select flow-control hysteresis.
// RULE19: Enhanced bit 6 selects delayed or immediate line error interrupt.
// RULE20: Enhanced bit 7 selects 16X sampling, clear selects 8X.
// RULE21: With swap set, scratch reads return the FIFO level count.
// RULE22: Reading modem status clears the change flags that were read.
// RULE23: Error flags follow the tags of each newly readable character.
//
// Local design decisions: the APB interface to the registers and the address map.
`default_nettype none

module ulms_status
  import ulms_pkg::*;
#(
  parameter int RX_DEPTH = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ulms_rx_char_t rx_char,
  input wire logic rx_read,
  input wire logic [7:0] tx_fifo_count,
  input wire logic tx_shift_busy,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ring_indicate_n,
  input wire logic carrier_detect_n,
  output logic rx_data_ready,
  output logic tx_stop,
  output logic dir_ctl,
  output logic modem_irq,
  output logic lsr_irq,
  output logic [5:0] rts_hyst,
  output logic sample_16x
);

  localparam int AW = $clog2(RX_DEPTH);
  localparam int LW = $clog2(RX_DEPTH + 1);

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode.

  logic setup_acc;
  logic done;
  logic hit;
  logic wr_done;
  logic rd_done;
  logic [CTL_WIDTH-1:0] control;
  logic [7:0] scratch_byte;
  logic [7:0] enhanced_mode_select;
  logic [7:0] feature_control;
  logic [7:0] line_status;
  logic [7:0] modem_status;
  logic [7:0] level_report;

  // Each access gets one wait state so that read data comes from a flop.
  assign setup_acc = psel & penable & ~pready;
  assign done = psel & penable & pready;
  assign hit = (paddr == OFS_LINE_STATUS) | (paddr == OFS_MODEM_STATUS) |
               (paddr == OFS_SCRATCH) | (paddr == OFS_CONTROL);
  assign wr_done = done & pwrite & hit;
  assign rd_done = done & ~pwrite & hit;
  assign feature_control = control[CTL_FEATURE_CONTROL_LSB +: 8];

  ////////////////////////////////////////////////////////////////////////////
  // Receive tag store and level.

  ulms_tag_t tag_mem [RX_DEPTH];
  ulms_tag_t head;
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [LW-1:0] rx_level;
  logic [LW-1:0] next_level;
  logic [LW-1:0] err_cnt;
  logic full;
  logic take;
  logic push;
  logic pop;
  logic ovr_evt;
  logic brk_hold;
  logic overrun;
  logic err_imm;

  function automatic logic has_err(input ulms_tag_t t);
    return t.brk | t.frm | t.par;
  endfunction

  // Outside FIFO mode the receive path holds exactly one character.
  assign full = rx_level == (control[CTL_FIFO] ? LW'(RX_DEPTH) : LW'(1));
  assign take = rx_char.valid & ~(rx_char.tag.brk & brk_hold); // [RULE5]
  assign push = take & ~full;
  assign ovr_evt = take & full; // [RULE2]
  assign pop = rx_read & (rx_level != '0);
  assign head = tag_mem[rd_ptr];

  // Level bookkeeping; a full store drops the new character untouched.
  always_comb begin
    next_level = rx_level;
    if (push & ~pop) begin
      next_level = rx_level + LW'(1);
    end else if (pop & ~push) begin
      next_level = rx_level - LW'(1);
    end
  end

  // Tags are written at the tail; the array itself needs no reset.
  always_ff @(posedge pclk) begin
    if (push) begin
      tag_mem[wr_ptr] <= rx_char.tag;
    end
  end

  // Pointers wrap naturally, so the depth must be a power of two.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      rx_level <= '0;
      rx_data_ready <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      rx_level <= next_level;
      rx_data_ready <= next_level != '0; // [RULE1]
    end
  end

  // Count of stored characters with any error tag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_cnt <= '0;
    end else begin
      err_cnt <= err_cnt + LW'(push & has_err(rx_char.tag)) - LW'(pop & has_err(head)); // [RULE8]
    end
  end

  // A break is stored once; the next normal character rearms it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_hold <= 1'b0;
    end else if (rx_char.valid) begin
      brk_hold <= rx_char.tag.brk; // [RULE5]
    end
  end

  // Overrun is cleared only if the host saw it, the immediate error flag on any line status read; a new set wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun <= 1'b0;
      err_imm <= 1'b0;
    end else begin
      if (ovr_evt) begin
        overrun <= 1'b1; // [RULE2]
      end else if (rd_done & (paddr == OFS_LINE_STATUS) & prdata[LS_OVERRUN]) begin
        overrun <= 1'b0;
      end
      if (push & has_err(rx_char.tag)) begin
        err_imm <= 1'b1;
      end else if (rd_done & (paddr == OFS_LINE_STATUS)) begin
        err_imm <= 1'b0;
      end
    end
  end

  // Error tags belong to the readable head character only.
  always_comb begin
    line_status = 8'h00;
    line_status[LS_READY] = rx_data_ready; // [RULE1]
    line_status[LS_OVERRUN] = overrun;
    line_status[LS_PARITY] = rx_data_ready & head.par; // [RULE3] [RULE23]
    line_status[LS_FRAMING] = rx_data_ready & head.frm; // [RULE4] [RULE23]
    line_status[LS_BREAK] = rx_data_ready & head.brk; // [RULE5] [RULE23]
    line_status[LS_THR_EMPTY] = tx_fifo_count == 8'h00; // [RULE6]
    line_status[LS_TX_IDLE] = (tx_fifo_count == 8'h00) & ~tx_shift_busy; // [RULE7]
    line_status[LS_FIFO_ERR] = err_cnt != '0; // [RULE8]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modem status.

  logic [3:0] lvl;
  logic [3:0] lvl_prev;
  logic [3:0] delta;
  logic primed;
  logic [3:0] next_delta;

  // Levels ordered cts, dsr, ring, carrier; loopback feeds back the modem control bits.
  assign lvl = control[CTL_LOOP] ?
               {control[CTL_MC_OUT2], control[CTL_MC_OUT1], control[CTL_MC_DTR], control[CTL_MC_RTS]} :
               ~{carrier_detect_n, ring_indicate_n, dsr_n, cts_n}; // [RULE12]

  // Ring only counts its trailing edge: level 1 to 0 means the pin went high.
  always_comb begin
    next_delta = delta;
    if (rd_done & (paddr == OFS_MODEM_STATUS)) begin
      next_delta = delta & ~prdata[3:0]; // [RULE22]
    end
    if (primed) begin
      next_delta[0] = next_delta[0] | (lvl[0] ^ lvl_prev[0]); // [RULE9]
      next_delta[1] = next_delta[1] | (lvl[1] ^ lvl_prev[1]);
      next_delta[2] = next_delta[2] | (lvl_prev[2] & ~lvl[2]); // [RULE10]
      next_delta[3] = next_delta[3] | (lvl[3] ^ lvl_prev[3]);
    end
  end

  // The first cycle after reset only primes the history, avoiding a false change.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_prev <= 4'h0;
      delta <= 4'h0;
      primed <= 1'b0;
    end else begin
      lvl_prev <= lvl;
      delta <= next_delta;
      primed <= 1'b1;
    end
  end

  assign modem_status = {lvl, delta};

  ////////////////////////////////////////////////////////////////////////////
  // Scratch, enhanced mode and control registers.

  logic alt_tx;

  // Swap routes scratch-location writes into the enhanced mode register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scratch_byte <= SCRATCH_RESET; // [RULE13]
      enhanced_mode_select <= ENHANCED_MODE_SELECT_RESET; // [RULE20]
      control <= CTL_RESET;
    end else if (wr_done) begin
      if (paddr == OFS_SCRATCH) begin
        if (feature_control[FEATURE_CONTROL_SWAP]) begin
          enhanced_mode_select <= pwdata[7:0]; // [RULE14]
        end else begin
          scratch_byte <= pwdata[7:0]; // [RULE13]
        end
      end
      if (paddr == OFS_CONTROL) begin
        control <= pwdata[CTL_WIDTH-1:0];
      end
    end
  end

  // Alternation restarts on receive each time the mode register is written.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_tx <= 1'b0;
    end else if (wr_done & (paddr == OFS_SCRATCH) & feature_control[FEATURE_CONTROL_SWAP]) begin
      alt_tx <= 1'b0; // [RULE16]
    end else if (rd_done & (paddr == OFS_SCRATCH) & feature_control[FEATURE_CONTROL_SWAP] &
                 (enhanced_mode_select[EM_CNT_ALT:EM_CNT_SEL] == 2'b11)) begin
      alt_tx <= ~alt_tx; // [RULE16]
    end
  end

  // Level report chosen by the low two mode bits.
  always_comb begin
    level_report = 8'(rx_level); // [RULE15]
    if (enhanced_mode_select[EM_CNT_SEL] & (~enhanced_mode_select[EM_CNT_ALT] | alt_tx)) begin
      level_report = tx_fifo_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer, registered so that all outputs leave flops.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_acc;
      pslverr <= setup_acc & ~hit;
      prdata <= 32'h0000_0000;
      if (setup_acc & ~pwrite) begin
        case (paddr)
          OFS_LINE_STATUS: prdata <= {24'h000000, line_status};
          OFS_MODEM_STATUS: prdata <= {24'h000000, modem_status};
          OFS_SCRATCH: prdata <= {24'h000000, feature_control[FEATURE_CONTROL_SWAP] ? level_report : scratch_byte}; // [RULE21]
          OFS_CONTROL: prdata <= {16'h0000, control};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line-side outputs.

  logic tx_active;

  assign tx_active = (tx_fifo_count != 8'h00) | tx_shift_busy;

  // Transmitter checks tx_stop only between characters, so a character in flight finishes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_stop <= 1'b0;
      dir_ctl <= 1'b1;
      modem_irq <= 1'b0;
      lsr_irq <= 1'b0;
      rts_hyst <= 6'h00;
      sample_16x <= 1'b1;
    end else begin
      tx_stop <= control[CTL_AUTO_CTS] & ~lvl[0]; // [RULE11]
      dir_ctl <= tx_active ? enhanced_mode_select[EM_DIR_INV] : ~enhanced_mode_select[EM_DIR_INV]; // [RULE17]
      modem_irq <= control[CTL_MSI_EN] & (delta != 4'h0); // [RULE9]
      lsr_irq <= enhanced_mode_select[EM_IMMEDIATE] ? err_imm :
                 (rx_data_ready & has_err(head)); // [RULE19]
      rts_hyst <= HYST_TABLE[{enhanced_mode_select[EM_HYST_LSB +: 2], feature_control[1:0]}]; // [RULE18]
      sample_16x <= enhanced_mode_select[EM_SAMPLE_16X]; // [RULE20]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_ready_level: assert property (rx_data_ready == (rx_level != '0)) // [RULE1]
    else $error("ready flag disagrees with receive level");
  a_overrun_set: assert property (ovr_evt |=> overrun) // [RULE2]
    else $error("overrun not flagged");
  a_fifo_kept: assert property ((ovr_evt & ~pop) |=> $stable(rx_level)) // [RULE2]
    else $error("full receive store changed on overrun");
  a_err_summary: assert property ((push & has_err(rx_char.tag)) |=> err_cnt != '0) // [RULE8]
    else $error("error summary missed a tagged byte");
  a_ring_edge: assert property ((primed & ~delta[2] & ~(lvl_prev[2] & ~lvl[2])) |=> ~delta[2]) // [RULE10]
    else $error("ring change set without a rising pin");
  a_cts_stop: assert property ((control[CTL_AUTO_CTS] & ~lvl[0]) |=> tx_stop) // [RULE11]
    else $error("transmit not stopped");
  a_swap_write: assert property ((wr_done & (paddr == OFS_SCRATCH) & feature_control[FEATURE_CONTROL_SWAP])
    |=> $stable(scratch_byte) & ~alt_tx) // [RULE14]
    else $error("swapped write reached scratch byte");
  a_dir_polarity: assert property (##1 dir_ctl == // [RULE17]
    ($past(tx_active) ^ ~$past(enhanced_mode_select[EM_DIR_INV])))
    else $error("direction output polarity wrong");

endmodule // ulms_status

`default_nettype wire

/* sim/ulms_remote.sv */
// Model of the remote serial device and modem that sit on the far side of the status block.
// Assumes the bench calls its tasks from one process and that pclk is the only clock.
`default_nettype none

module ulms_remote
  import ulms_pkg::*;
(
  input wire logic pclk,
  output ulms_rx_char_t rx_char,
  output logic [3:0] pins_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // The line starts idle with every modem pin inactive, which is high on these active-low pins.
  initial begin
    rx_char = '0;
    pins_n = 4'hf;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // A completed character lasts exactly one cycle, so a slow caller cannot stretch it into two.
  task automatic send(input logic [2:0] tag);
    @(posedge pclk);
    rx_char <= {1'b1, tag};
    @(posedge pclk);
    rx_char <= '0;
  endtask

  // Pin levels are in the order carrier, ring, data-set-ready, clear-to-send from the top bit.
  task automatic set_pins(input logic [3:0] val);
    @(posedge pclk);
    pins_n <= val;
  endtask
endmodule // ulms_remote

`default_nettype wire

/* sim/tb_uart_line_modem_status_enhanced_mode.sv */
// Self-checking bench of the line and modem status block, with a queue model of the receive store.
// Assumes the remote model drives the line side and an APB master task reaches the registers.
`default_nettype none

module tb_uart_line_modem_status_enhanced_mode
  import ulms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, rx_read, tx_busy, pready, pslverr, err;
  logic tx_stop, dir_ctl, modem_irq, lsr_irq, s16, ovr, lastb, rdy;
  logic [7:0] paddr, tx_cnt, scr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [15:0] ctl;
  logic [5:0] hyst;
  logic [3:0] pins_n, v;
  logic [2:0] rq[$];
  ulms_rx_char_t rx_char;
  int err_count, n_tests, cyc;
  logic [5:0] htab[16] = '{6'h00, 6'h04, 6'h06, 6'h08, 6'h08, 6'h10, 6'h18, 6'h20,
                           6'h28, 6'h2c, 6'h30, 6'h34, 6'h0c, 6'h14, 6'h1c, 6'h24};
  // Receive tags sent in FIFO mode, and the level reads expected in alternating mode.
  logic [2:0] fifo_seq[6] = '{3'h0, 3'h1, 3'h4, 3'h4, 3'h2, 3'h0};
  logic [7:0] alt_seq[4] = '{8'h04, 8'h03, 8'h04, 8'h03};

  ulms_status #(.RX_DEPTH(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_char(rx_char), .rx_read(rx_read), .tx_fifo_count(tx_cnt), .tx_shift_busy(tx_busy),
    .cts_n(pins_n[0]), .dsr_n(pins_n[1]), .ring_indicate_n(pins_n[2]), .carrier_detect_n(pins_n[3]),
    .rx_data_ready(rdy), .tx_stop(tx_stop), .dir_ctl(dir_ctl), .modem_irq(modem_irq), .lsr_irq(lsr_irq),
    .rts_hyst(hyst), .sample_16x(s16));
  ulms_remote remote_u (.pclk(pclk), .rx_char(rx_char), .pins_n(pins_n));

  // Free-running 40 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // A hang anywhere counts as a mismatch; the whole run needs far fewer cycles than this.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer: the request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e & m);
  endtask

  // Expected line status from the queue model; head tags mean nothing once the store is empty.
  function automatic logic [7:0] ls_exp();
    logic fe;
    fe = 1'b0;
    foreach (rq[k]) fe |= (rq[k] != 3'h0);
    return {fe, tx_cnt == 8'h0 && !tx_busy, tx_cnt == 8'h0, (rq.size() != 0) ? rq[0] : 3'h0, ovr, rq.size() != 0};
  endfunction

  // A status read that showed overrun clears it, so the model drops it after every read.
  // The model is consulted after the access, so stimulus set on the calling edge has settled.
  task automatic chk_ls(input logic [31:0] m);
    logic [31:0] mm;
    mm = (rq.size() != 0) ? m : m & 32'he3;
    apb(1'b0, OFS_LINE_STATUS, 32'h0);
    chk(rd & mm, {24'h0, ls_exp()} & mm);
    chk(rdy, rq.size() != 0);
    ovr = 1'b0;
  endtask

  // The store is one deep outside FIFO mode; a repeated break is not stored again.
  task automatic push(input logic [2:0] t);
    remote_u.send(t);
    if (!(t[2] && lastb)) begin
      if (rq.size() >= (ctl[CTL_FIFO] ? 4 : 1)) ovr = 1'b1;
      else rq.push_back(t);
    end
    lastb = t[2];
    @(posedge pclk);
  endtask

  task automatic pop();
    @(posedge pclk);
    rx_read <= 1'b1;
    @(posedge pclk);
    rx_read <= 1'b0;
    void'(rq.pop_front());
  endtask

  task automatic wctl(input logic [15:0] c);
    ctl = c;
    apb(1'b1, OFS_CONTROL, {16'h0, c});
  endtask

  task automatic stop_test();
    $display("errors=%0d checks=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {psel, penable, pwrite, rx_read, tx_busy, ovr, lastb} = '0;
    {paddr, tx_cnt, pwdata, ctl, cyc, err_count, n_tests} = '0;
    seed = 32'd43621;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk_ls(32'hff);
    rdc(OFS_MODEM_STATUS, 32'h0, 32'hff);
    rdc(OFS_SCRATCH, 32'hff, 32'hffffffff);
    rdc(8'h10, 32'h0, 32'hffffffff);
    chk(err, 1'b1);
    chk(s16, 1'b1);
    chk(dir_ctl, 1'b1);
    scr = 8'(rnd());
    apb(1'b1, OFS_SCRATCH, {24'h0, scr});
    rdc(OFS_SCRATCH, {24'h0, scr}, 32'hffffffff);
    // Single-entry store: the second character overruns and must not replace the head.
    push(3'h0);
    push(3'h1);
    chk_ls(32'hff);
    chk_ls(32'hff);
    pop();
    chk_ls(32'hff);
    // FIFO mode: a repeated break is dropped, the sixth character overruns.
    wctl(16'h0020);
    foreach (fifo_seq[k]) push(fifo_seq[k]);
    tx_cnt <= 8'h03;
    wctl(16'h4020);
    apb(1'b1, OFS_SCRATCH, 32'h83);
    foreach (alt_seq[k]) rdc(OFS_SCRATCH, {24'h0, alt_seq[k]}, 32'hff);
    apb(1'b1, OFS_SCRATCH, 32'h81);
    rdc(OFS_SCRATCH, 32'h3, 32'hff);
    apb(1'b1, OFS_SCRATCH, 32'h80);
    rdc(OFS_SCRATCH, 32'h4, 32'hff);
    wctl(16'h0020);
    rdc(OFS_SCRATCH, {24'h0, scr}, 32'hff);
    tx_cnt <= 8'h00;
    repeat (4) begin
      // The interrupt follows the new head two edges after a pop.
      repeat (2) @(posedge pclk);
      chk(lsr_irq, rq[0] != 3'h0);
      chk_ls(32'hff);
      pop();
    end
    chk_ls(32'hff);
    // Immediate error interrupt fires although the faulty character is not at the head.
    wctl(16'h4020);
    apb(1'b1, OFS_SCRATCH, 32'hc0);
    push(3'h0);
    push(3'h1);
    repeat (3) @(posedge pclk);
    chk(lsr_irq, 1'b1);
    chk_ls(32'hff);
    pop();
    pop();
    // Every hysteresis code, with polarity and sampling rate varied alongside.
    tx_cnt <= 8'h03;
    for (int i = 0; i < 16; i++) begin
      wctl({6'h10, i[1:0], 8'h20});
      apb(1'b1, OFS_SCRATCH, {24'h0, i[1], 1'b0, i[3:2], i[0], 3'h0});
      repeat (3) @(posedge pclk);
      chk(hyst, htab[i]);
      chk(s16, i[1]);
      chk(dir_ctl, i[0]);
    end
    for (int i = 0; i < 4; i++) begin
      tx_cnt <= i[0] ? (8'(rnd()) | 8'h01) : 8'h00;
      tx_busy <= i[1];
      chk_ls(32'h60);
    end
    // Modem changes: the falling ring pin must not flag, its rise must.
    wctl(16'h0080);
    remote_u.set_pins(4'h0);
    repeat (4) @(posedge pclk);
    chk(modem_irq, 1'b1);
    rdc(OFS_MODEM_STATUS, 32'hfb, 32'hff);
    rdc(OFS_MODEM_STATUS, 32'hf0, 32'hff);
    repeat (3) @(posedge pclk);
    chk(modem_irq, 1'b0);
    remote_u.set_pins(4'h4);
    rdc(OFS_MODEM_STATUS, 32'hb4, 32'hff);
    remote_u.set_pins(4'hf);
    repeat (4) begin
      v = 4'(rnd());
      wctl({12'h001, v});
      rdc(OFS_MODEM_STATUS, {24'h0, v[3], v[2], v[0], v[1], 4'h0}, 32'hf0);
    end
    // Automatic clear-to-send: a high pin holds the transmitter, a low pin releases it.
    wctl(16'h0040);
    remote_u.set_pins(4'h5);
    repeat (3) @(posedge pclk);
    chk(tx_stop, 1'b1);
    remote_u.set_pins(4'h4);
    repeat (3) @(posedge pclk);
    chk(tx_stop, 1'b0);
    stop_test();
  end
endmodule // tb_uart_line_modem_status_enhanced_mode

`default_nettype wire
